/* pkg/ppp_defs.svh */
// Purpose: constants for the parallel programming port
// Assumes: included by bare name from design and verification files
// Notes: command codes, action codes, reset values, lock masks, timing figures
//
// Function
// - command 0001 0000 selects a flash page write
// - action 00 with primary select low loads the low address byte
// - action 00 with primary select high loads the high address byte
// - action 01 loads flash data low or high byte by primary select
// - page latch pulse with primary high stores data at current word
// - low address bits pick the word, upper bits pick the page
// - write pulse after page load programs the page, busy until done
// - command 0000 0000 is a no-op that clears write signals
// - eeprom write command 0001 0001, write pulse with primary low programs page
// - flash read command drives low or high byte by primary select
// - eeprom read command with primary low drives the addressed byte, 00 with primary high
// - fuse write command, selects pick low, high or extended fuse byte
// - lock write programs zero bits; lock mode 3 blocks boot lock bits
// - lock bits are never cleared by a lock write
// - fuse and lock read picks the byte by both selects
// - signature command drives signature byte 0 to 2
// - signature command with primary high drives calibration byte at address 0, 00 elsewhere
// - ready flag is 0 while programming, 1 when ready
// - data bus is driven only while read enable is low, one clock behind it
// - command and address are kept across operations
`ifndef PPP_DEFS_SVH
`define PPP_DEFS_SVH

// ----------------------------------------------------------------
// command bytes
// ----------------------------------------------------------------
`define PPP_CMD_NOP 8'h00
`define PPP_CMD_WR_FLASH 8'h10
`define PPP_CMD_WR_EEPROM 8'h11
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_LOCK 8'h20
`define PPP_CMD_RD_SIG 8'h08
`define PPP_CMD_RD_FUSE 8'h04
`define PPP_CMD_RD_FLASH 8'h02
`define PPP_CMD_RD_EEPROM 8'h03

// ----------------------------------------------------------------
// action select codes, reset values, timing
// ----------------------------------------------------------------
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_FUSE_RST 8'hff
`define PPP_LOCK_RST 8'hff
`define PPP_LOCK_LB_MASK 8'h03
`define PPP_LOCK_BOOT_MASK 8'h3c
`define PPP_PROG_TIME_US 10
`define PPP_CLK_MHZ 100
`define PPP_PROG_CYCLES (`PPP_PROG_TIME_US * `PPP_CLK_MHZ)

`endif

/* pkg/ppp_pkg.sv */
// Purpose: types for the parallel programming port
// Assumes: nothing
// Notes: states of the programming engine
package ppp_pkg;
    typedef enum logic [1:0] {
        PPP_IDLE = 2'b00,
        PPP_BUSY = 2'b01
    } ppp_state_t;
endpackage

/* logic/ppp_edge.sv */
// Purpose: synchronise one strobe pin and flag its active edge
// Assumes: pin aligned to clock
// Notes: ACTIVE_HIGH chooses rising (1) or falling (0) edge
`timescale 1ns/1ps
module ppp_edge #(
    parameter bit ACTIVE_HIGH = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic pulse
);
    logic s0;
    logic s1;
    logic s2;
    logic next_s0;
    logic next_s1;
    logic next_s2;

    // shift chain; s0 feeds only s1
    always_comb begin
        next_s0 = pin;
        next_s1 = s0;
        next_s2 = s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s0 <= ~ACTIVE_HIGH;
            s1 <= ~ACTIVE_HIGH;
            s2 <= ~ACTIVE_HIGH;
        end else begin
            s0 <= next_s0;
            s1 <= next_s1;
            s2 <= next_s2;
        end
    end

    // one pulse per active edge
    assign pulse = ACTIVE_HIGH ? (s1 & ~s2) : (~s1 & s2);
endmodule // ppp_edge

/* logic/ppp_timer.sv */
// Purpose: self-timed programming duration counter
// Assumes: start is a one-cycle pulse
// Notes: done pulses once after CYCLES clock cycles
`timescale 1ns/1ps
module ppp_timer #(
    parameter int CYCLES = 1000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    output logic done
);
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic next_done;

    initial begin
        if (CYCLES < 1) $error("ppp_timer: CYCLES must be at least 1");
    end

    // count down, pulse done at one
    always_comb begin
        next_cnt = cnt;
        next_done = 1'b0;
        if (start) begin
            next_cnt = 32'(CYCLES);
        end else if (cnt != 32'h0) begin
            next_cnt = cnt - 32'h1;
            next_done = (cnt == 32'h1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 32'h0;
            done <= 1'b0;
        end else begin
            cnt <= next_cnt;
            done <= next_done;
        end
    end
endmodule // ppp_timer

/* logic/ppp_port.sv */
// Purpose: device side of the parallel programming port
// Assumes: strobes and bus synchronous to SYS_CLK; high-voltage entry done
// Notes: memories are modelled as arrays; chip erase and serial path absent
`timescale 1ns/1ps
`include "ppp_defs.svh"
module ppp_port #(
    parameter int PAGE_WORDS = 32,
    parameter int FLASH_WORDS = 4096,
    parameter int EE_PAGE = 4,
    parameter int EE_BYTES = 512,
    parameter int PROG_CYCLES = `PPP_PROG_CYCLES,
    parameter logic [7:0] SIG0 = 8'h5a, // arbitrary value
    parameter logic [7:0] SIG1 = 8'h5b, // arbitrary value
    parameter logic [7:0] SIG2 = 8'h5c, // arbitrary value
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic LOAD_STROBE_PIN,
    input wire logic ACTION_SELECT_HI,
    input wire logic ACTION_SELECT_LO,
    input wire logic BYTE_SELECT_PRIMARY,
    input wire logic BYTE_SELECT_SECONDARY,
    input wire logic PAGE_LATCH_STROBE,
    input wire logic WRITE_N,
    input wire logic READ_EN_N,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE,
    output logic READY_BUSY_FLAG,
    output logic [7:0] FUSE_LOW,
    output logic [7:0] FUSE_HIGH,
    output logic [7:0] FUSE_EXT,
    output logic [7:0] LOCK_BITS
);
    localparam int PW = $clog2(PAGE_WORDS);
    localparam int FW = $clog2(FLASH_WORDS);
    localparam int EW = $clog2(EE_PAGE);
    localparam int EBW = $clog2(EE_BYTES);

    initial begin
        if (PAGE_WORDS < 2 || PAGE_WORDS > 256 || FW > 16 || PW >= FW)
            $error("ppp_port: flash geometry not supported");
        if (EE_PAGE < 2 || EW >= EBW || EBW > 16)
            $error("ppp_port: eeprom geometry not supported");
    end

    // ----------------------------------------------------------------
    // strobe edge detection
    // ----------------------------------------------------------------
    logic load_p;
    logic latch_p;
    logic write_p;
    logic busy_done;

    ppp_edge #(.ACTIVE_HIGH(1'b1)) u_load (.clk(SYS_CLK), .rst(RST), .pin(LOAD_STROBE_PIN), .pulse(load_p));
    ppp_edge #(.ACTIVE_HIGH(1'b1)) u_latch (.clk(SYS_CLK), .rst(RST), .pin(PAGE_LATCH_STROBE), .pulse(latch_p));
    ppp_edge #(.ACTIVE_HIGH(1'b0)) u_write (.clk(SYS_CLK), .rst(RST), .pin(WRITE_N), .pulse(write_p));

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [15:0] flash_mem [FLASH_WORDS];
    logic [7:0] ee_mem [EE_BYTES];
    logic [15:0] flash_buf [PAGE_WORDS];
    logic [7:0] ee_buf [EE_PAGE];
    logic [PAGE_WORDS-1:0] flash_vld;
    logic [EE_PAGE-1:0] ee_vld;

    // ----------------------------------------------------------------
    // command, address, data holding registers
    // ----------------------------------------------------------------
    logic [7:0] cmd;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] data_lo;
    logic [7:0] data_hi;
    logic [7:0] next_cmd;
    logic [7:0] next_addr_lo;
    logic [7:0] next_addr_hi;
    logic [7:0] next_data_lo;
    logic [7:0] next_data_hi;
    logic [1:0] act;
    logic [15:0] addr;

    assign act = {ACTION_SELECT_HI, ACTION_SELECT_LO};
    assign addr = {addr_hi, addr_lo};

    // loads only while idle; values persist across operations
    always_comb begin
        next_cmd = cmd;
        next_addr_lo = addr_lo;
        next_addr_hi = addr_hi;
        next_data_lo = data_lo;
        next_data_hi = data_hi;
        if (load_p && READY_BUSY_FLAG) begin
            case (act)
                `PPP_ACT_CMD: begin
                    if (!BYTE_SELECT_PRIMARY) next_cmd = DATA_IN;
                end
                `PPP_ACT_ADDR: begin
                    if (BYTE_SELECT_PRIMARY) next_addr_hi = DATA_IN;
                    else next_addr_lo = DATA_IN;
                end
                `PPP_ACT_DATA: begin
                    if (BYTE_SELECT_PRIMARY) next_data_hi = DATA_IN;
                    else next_data_lo = DATA_IN;
                end
                default: begin
                    next_cmd = cmd; // idle action
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            cmd <= `PPP_CMD_NOP;
            addr_lo <= 8'h00;
            addr_hi <= 8'h00;
            data_lo <= 8'hff;
            data_hi <= 8'hff;
        end else begin
            cmd <= next_cmd;
            addr_lo <= next_addr_lo;
            addr_hi <= next_addr_hi;
            data_lo <= next_data_lo;
            data_hi <= next_data_hi;
        end
    end

    // ----------------------------------------------------------------
    // programming engine
    // ----------------------------------------------------------------
    ppp_pkg::ppp_state_t state;
    ppp_pkg::ppp_state_t next_state;
    logic start_prog;
    logic next_busy;
    logic cmd_nop_p;
    logic [7:0] lock_req;

    ppp_timer #(.CYCLES(PROG_CYCLES)) u_timer (.clk(SYS_CLK), .rst(RST), .start(start_prog), .done(busy_done));

    assign cmd_nop_p = load_p && READY_BUSY_FLAG && act == `PPP_ACT_CMD && !BYTE_SELECT_PRIMARY
                       && DATA_IN == `PPP_CMD_NOP;

    // a write pulse starts a self-timed operation for write commands, eeprom only with primary low
    always_comb begin
        start_prog = 1'b0;
        next_state = state;
        case (state)
            ppp_pkg::PPP_IDLE: begin
                if (write_p) begin
                    case (cmd)
                        `PPP_CMD_WR_FLASH: start_prog = 1'b1;
                        `PPP_CMD_WR_EEPROM: start_prog = !BYTE_SELECT_PRIMARY;
                        `PPP_CMD_WR_FUSE: start_prog = 1'b1;
                        `PPP_CMD_WR_LOCK: start_prog = 1'b1;
                        default: start_prog = 1'b0;
                    endcase
                end
                if (start_prog) next_state = ppp_pkg::PPP_BUSY;
            end
            ppp_pkg::PPP_BUSY: begin
                if (busy_done) next_state = ppp_pkg::PPP_IDLE;
            end
            default: next_state = ppp_pkg::PPP_IDLE;
        endcase
        next_busy = (next_state == ppp_pkg::PPP_IDLE);
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state <= ppp_pkg::PPP_IDLE;
            READY_BUSY_FLAG <= 1'b1;
        end else begin
            state <= next_state;
            READY_BUSY_FLAG <= next_busy;
        end
    end

    // lock write can only program bits; boot bits frozen under mode 3
    always_comb begin
        lock_req = LOCK_BITS & data_lo;
        if ((LOCK_BITS & `PPP_LOCK_LB_MASK) == 8'h00) begin
            lock_req = (lock_req & ~`PPP_LOCK_BOOT_MASK) | (LOCK_BITS & `PPP_LOCK_BOOT_MASK);
        end
    end

    // ----------------------------------------------------------------
    // page buffers, memory arrays, fuses and lock bits
    // ----------------------------------------------------------------
    // no reset on arrays: they model nonvolatile storage, preloaded erased
    initial begin
        for (int i = 0; i < FLASH_WORDS; i++) flash_mem[i] = 16'hffff;
        for (int i = 0; i < EE_BYTES; i++) ee_mem[i] = 8'hff;
    end

    always_ff @(posedge SYS_CLK) begin
        if (READY_BUSY_FLAG && latch_p && BYTE_SELECT_PRIMARY && cmd == `PPP_CMD_WR_FLASH)
            flash_buf[addr_lo[PW-1:0]] <= {data_hi, data_lo};
        if (READY_BUSY_FLAG && latch_p && cmd == `PPP_CMD_WR_EEPROM)
            ee_buf[addr_lo[EW-1:0]] <= data_lo;
        if (start_prog && cmd == `PPP_CMD_WR_FLASH) begin
            for (int i = 0; i < PAGE_WORDS; i++)
                if (flash_vld[i]) flash_mem[{addr[FW-1:PW], PW'(i)}] <= flash_buf[i];
        end
        if (start_prog && cmd == `PPP_CMD_WR_EEPROM) begin
            for (int i = 0; i < EE_PAGE; i++)
                if (ee_vld[i]) ee_mem[{addr[EBW-1:EW], EW'(i)}] <= ee_buf[i];
        end
    end

    // valid masks: filled by latches, emptied by programming or no-op
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            flash_vld <= '0;
            ee_vld <= '0;
        end else begin
            // clear first so a latch in the same cycle still sets its bit
            if (cmd_nop_p || start_prog) begin
                flash_vld <= '0;
                ee_vld <= '0;
            end
            if (READY_BUSY_FLAG && latch_p && BYTE_SELECT_PRIMARY && cmd == `PPP_CMD_WR_FLASH)
                flash_vld[addr_lo[PW-1:0]] <= 1'b1;
            if (READY_BUSY_FLAG && latch_p && cmd == `PPP_CMD_WR_EEPROM)
                ee_vld[addr_lo[EW-1:0]] <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            FUSE_LOW <= `PPP_FUSE_RST;
            FUSE_HIGH <= `PPP_FUSE_RST;
            FUSE_EXT <= `PPP_FUSE_RST;
            LOCK_BITS <= `PPP_LOCK_RST;
        end else if (start_prog) begin
            if (cmd == `PPP_CMD_WR_FUSE) begin
                if (BYTE_SELECT_SECONDARY && !BYTE_SELECT_PRIMARY) FUSE_EXT <= data_lo;
                else if (BYTE_SELECT_PRIMARY && !BYTE_SELECT_SECONDARY) FUSE_HIGH <= data_lo;
                else if (!BYTE_SELECT_PRIMARY) FUSE_LOW <= data_lo;
            end
            if (cmd == `PPP_CMD_WR_LOCK) LOCK_BITS <= lock_req;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [7:0] next_dout;
    logic next_oe;
    logic [15:0] rd_word;
    logic [7:0] rd_ee;

    assign rd_word = flash_mem[addr[FW-1:0]];
    assign rd_ee = ee_mem[addr[EBW-1:0]];

    // read data chosen by command and byte selects
    always_comb begin
        next_oe = !READ_EN_N;
        next_dout = 8'h00;
        case (cmd)
            `PPP_CMD_RD_FLASH: next_dout = BYTE_SELECT_PRIMARY ? rd_word[15:8] : rd_word[7:0];
            `PPP_CMD_RD_EEPROM: next_dout = BYTE_SELECT_PRIMARY ? 8'h00 : rd_ee;
            `PPP_CMD_RD_FUSE: begin
                case ({BYTE_SELECT_SECONDARY, BYTE_SELECT_PRIMARY})
                    2'b00: next_dout = FUSE_LOW;
                    2'b11: next_dout = FUSE_HIGH;
                    2'b10: next_dout = FUSE_EXT;
                    default: next_dout = LOCK_BITS;
                endcase
            end
            `PPP_CMD_RD_SIG: begin
                if (BYTE_SELECT_PRIMARY) next_dout = (addr_lo == 8'h00) ? CAL_BYTE : 8'h00;
                else begin
                    case (addr_lo)
                        8'h00: next_dout = SIG0;
                        8'h01: next_dout = SIG1;
                        8'h02: next_dout = SIG2;
                        default: next_dout = 8'h00;
                    endcase
                end
            end
            default: next_dout = 8'h00;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            DATA_OUT <= 8'h00;
            DATA_OE <= 1'b0;
        end else begin
            DATA_OUT <= next_dout;
            DATA_OE <= next_oe;
        end
    end
endmodule // ppp_port

/* verif/ppp_port_sva.sv */
// Purpose: checks on the programming port
// Assumes: one clock domain
// Notes: command tracked from load strobe
`timescale 1ns/1ps
`include "ppp_defs.svh"
module ppp_port_sva #(
    parameter int PROG_CYCLES = 4
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic LOAD_STROBE_PIN,
    input wire logic ACTION_SELECT_HI,
    input wire logic ACTION_SELECT_LO,
    input wire logic BYTE_SELECT_PRIMARY,
    input wire logic BYTE_SELECT_SECONDARY,
    input wire logic WRITE_N,
    input wire logic READ_EN_N,
    input wire logic [7:0] DATA_IN,
    input wire logic [7:0] DATA_OUT,
    input wire logic DATA_OE,
    input wire logic READY_BUSY_FLAG,
    input wire logic [7:0] FUSE_LOW,
    input wire logic [7:0] FUSE_HIGH,
    input wire logic [7:0] LOCK_BITS
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    logic [7:0] cmd, next_cmd;
    logic lp, rdf;
    logic [15:0] busy_cnt, next_busy_cnt;
    // ----------------------------------------------------------------
    // helper state
    // ----------------------------------------------------------------
    // device drops loads while busy
    always_comb begin
        next_cmd = cmd;
        rdf = cmd == `PPP_CMD_RD_FUSE && !READ_EN_N;
        if (LOAD_STROBE_PIN && !lp && ACTION_SELECT_HI && !ACTION_SELECT_LO
            && !BYTE_SELECT_PRIMARY && READY_BUSY_FLAG) begin
            next_cmd = DATA_IN;
        end
        next_busy_cnt = READY_BUSY_FLAG ? 16'h0 : busy_cnt + 16'h1;
    end
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            cmd <= `PPP_CMD_NOP;
            lp <= 1'b0;
            busy_cnt <= 16'h0;
        end else begin
            cmd <= next_cmd;
            lp <= LOAD_STROBE_PIN;
            busy_cnt <= next_busy_cnt;
        end
    end
    property p_oe_on;
        !READ_EN_N |=> DATA_OE;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("bus not driven on read");
    property p_oe_off;
        READ_EN_N |=> !DATA_OE;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("bus driven without read");
    property p_busy_start;
        $fell(WRITE_N) && READY_BUSY_FLAG && (cmd == `PPP_CMD_WR_FUSE || cmd == `PPP_CMD_WR_LOCK)
            |-> ##[1:5] !READY_BUSY_FLAG;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("write did not go busy");
    property p_busy_len;
        $rose(READY_BUSY_FLAG) |-> busy_cnt == PROG_CYCLES + 1;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_lock_keep;
        !RST |=> (LOCK_BITS & ~$past(LOCK_BITS)) == 8'h00;
    endproperty
    a_lock_keep: assert property (p_lock_keep) else $error("lock bit cleared");
    property p_boot_frozen;
        LOCK_BITS[1:0] == 2'h0 |=> LOCK_BITS[5:2] == $past(LOCK_BITS[5:2]);
    endproperty
    a_boot_frozen: assert property (p_boot_frozen) else $error("boot lock changed in mode 3");
    property p_rd_fuse_lo;
        rdf && !BYTE_SELECT_SECONDARY && !BYTE_SELECT_PRIMARY
            |=> DATA_OUT == $past(FUSE_LOW);
    endproperty
    a_rd_fuse_lo: assert property (p_rd_fuse_lo) else $error("low fuse read wrong");
    property p_rd_fuse_hi;
        rdf && BYTE_SELECT_SECONDARY && BYTE_SELECT_PRIMARY
            |=> DATA_OUT == $past(FUSE_HIGH);
    endproperty
    a_rd_fuse_hi: assert property (p_rd_fuse_hi) else $error("high fuse read wrong");
    property p_rd_lock;
        rdf && !BYTE_SELECT_SECONDARY && BYTE_SELECT_PRIMARY
            |=> DATA_OUT == $past(LOCK_BITS);
    endproperty
    a_rd_lock: assert property (p_rd_lock) else $error("lock read wrong");
endmodule // ppp_port_sva
bind ppp_port ppp_port_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (.SYS_CLK(SYS_CLK), .RST(RST),
    .LOAD_STROBE_PIN(LOAD_STROBE_PIN), .ACTION_SELECT_HI(ACTION_SELECT_HI),
    .ACTION_SELECT_LO(ACTION_SELECT_LO), .BYTE_SELECT_PRIMARY(BYTE_SELECT_PRIMARY),
    .BYTE_SELECT_SECONDARY(BYTE_SELECT_SECONDARY), .WRITE_N(WRITE_N), .READ_EN_N(READ_EN_N),
    .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .READY_BUSY_FLAG(READY_BUSY_FLAG),
    .FUSE_LOW(FUSE_LOW), .FUSE_HIGH(FUSE_HIGH), .LOCK_BITS(LOCK_BITS));

/* verif/ppp_prog_model.sv */
// Purpose: external programmer model
// Assumes: device acts three edges after a strobe change
// Notes: strobes held four cycles each way
`timescale 1ns/1ps
module ppp_prog_model (
    input wire logic clk,
    input wire logic rdy,
    input wire logic [7:0] dout,
    output logic ld,
    output logic xa_hi,
    output logic xa_lo,
    output logic bs_p,
    output logic bs_s,
    output logic pl,
    output logic wr_n,
    output logic rd_n,
    output logic [7:0] d
);
    // pins change one ns after an edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    initial begin
        {ld, xa_hi, xa_lo, bs_p, bs_s, pl} = 6'h0c;
        {wr_n, rd_n} = 2'h3;
        d = 8'h00;
    end
    // ----------------------------------------------------------------
    // strobe sequences
    // ----------------------------------------------------------------
    task automatic load(input logic [1:0] act, input logic p, input logic [7:0] v);
        {xa_hi, xa_lo} = act;
        bs_p = p;
        d = v;
        ld = 1'b1;
        step(4);
        ld = 1'b0;
        step(4);
    endtask
    task automatic latch();
        bs_p = 1'b1;
        pl = 1'b1;
        step(4);
        pl = 1'b0;
        step(4);
    endtask
    // busy: ready seen low
    task automatic write(input logic p, input logic s, output logic busy);
        bs_p = p;
        bs_s = s;
        wr_n = 1'b0;
        busy = 1'b0;
        for (int i = 0; i < 4; i++) begin
            step(1);
            busy |= !rdy;
        end
        wr_n = 1'b1;
        // bounded so a stuck flag cannot hang
        for (int i = 0; i < 40 && rdy !== 1'b1; i++) begin
            step(1);
            busy |= !rdy;
        end
        step(3);
    endtask
    task automatic read(input logic p, input logic s, output logic [7:0] v);
        bs_p = p;
        bs_s = s;
        rd_n = 1'b0;
        d = ~d; // released bus shows inverse
        step(3);
        v = dout;
        rd_n = 1'b1;
        step(3);
    endtask
endmodule // ppp_prog_model

/* verif/testbench.sv */
// Purpose: bench for the programming port
// Assumes: short programming time of four cycles
// Notes: bus muxed by output enable
`timescale 1ns/1ps
`include "ppp_defs.svh"
module testbench;
    localparam logic [7:0] SIG [3] = '{8'h1e, 8'h2d, 8'h3c}; // arbitrary value
    localparam logic [7:0] CAL = 8'h77;
    logic clk, rst, ld, xa_hi, xa_lo, bs_p, bs_s, pl, wr_n, rd_n, oe, rdy;
    logic [7:0] d, bus, dout, f_lo, f_hi, f_ext, lock;
    int mismatches = 0;
    int n_tests = 0;
    assign bus = oe ? dout : d;
    ppp_port #(.PROG_CYCLES(4), .SIG0(SIG[0]), .SIG1(SIG[1]), .SIG2(SIG[2]), .CAL_BYTE(CAL)) u_dut (
        .SYS_CLK(clk), .RST(rst), .LOAD_STROBE_PIN(ld), .ACTION_SELECT_HI(xa_hi),
        .ACTION_SELECT_LO(xa_lo), .BYTE_SELECT_PRIMARY(bs_p), .BYTE_SELECT_SECONDARY(bs_s),
        .PAGE_LATCH_STROBE(pl), .WRITE_N(wr_n), .READ_EN_N(rd_n), .DATA_IN(bus), .DATA_OUT(dout),
        .DATA_OE(oe), .READY_BUSY_FLAG(rdy), .FUSE_LOW(f_lo), .FUSE_HIGH(f_hi), .FUSE_EXT(f_ext),
        .LOCK_BITS(lock));
    ppp_prog_model u_prog (.clk(clk), .rdy(rdy), .dout(dout), .ld(ld), .xa_hi(xa_hi), .xa_lo(xa_lo),
        .bs_p(bs_p), .bs_s(bs_s), .pl(pl), .wr_n(wr_n), .rd_n(rd_n), .d(d));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_flash();
        logic b;
        logic [7:0] lo, hi;
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_FLASH);
        u_prog.load(`PPP_ACT_ADDR, 1'b1, 8'h01);
        // page number partly in low byte
        for (int i = 0; i < 2; i++) begin
            u_prog.load(`PPP_ACT_ADDR, 1'b0, 8'h3e + 8'(i));
            u_prog.load(`PPP_ACT_DATA, 1'b0, 8'h30 + 8'(i));
            u_prog.load(`PPP_ACT_DATA, 1'b1, 8'hc0 + 8'(i));
            u_prog.latch();
        end
        u_prog.write(1'b0, 1'b0, b);
        chk("flash busy", 16'h1, {15'h0, b});
        chk("ready after", 16'h1, {15'h0, rdy});
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_NOP);
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_FLASH);
        for (int i = 0; i < 3; i++) begin
            u_prog.load(`PPP_ACT_ADDR, 1'b0, 8'h3d + 8'(i));
            u_prog.read(1'b0, 1'b0, lo);
            u_prog.read(1'b1, 1'b0, hi);
            chk("flash word", (i == 0) ? 16'hffff : {8'hbf + 8'(i), 8'h2f + 8'(i)}, {hi, lo});
        end
        $display("flash done");
    endtask
    task automatic t_eeprom();
        logic b;
        logic [7:0] v;
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_EEPROM);
        u_prog.load(`PPP_ACT_ADDR, 1'b1, 8'h00);
        for (int i = 0; i < 2; i++) begin
            u_prog.load(`PPP_ACT_ADDR, 1'b0, 8'h05 + 8'(i));
            u_prog.load(`PPP_ACT_DATA, 1'b0, 8'ha5 - 8'(i * 8'h69));
            u_prog.latch();
        end
        u_prog.write(1'b0, 1'b0, b);
        chk("eeprom busy", 16'h1, {15'h0, b});
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_EEPROM);
        for (int i = 0; i < 2; i++) begin
            u_prog.load(`PPP_ACT_ADDR, 1'b0, 8'h05 + 8'(i));
            u_prog.read(1'b0, 1'b0, v);
            chk("eeprom byte", {8'h00, 8'ha5 - 8'(i * 8'h69)}, {8'h00, v});
        end
        $display("eeprom done");
    endtask
    task automatic t_fuse();
        logic [7:0] fv [3] = '{8'he2, 8'hd9, 8'hf8};
        logic b;
        logic [7:0] v;
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_FUSE);
        for (int i = 0; i < 3; i++) begin
            u_prog.load(`PPP_ACT_DATA, 1'b0, fv[i]);
            u_prog.write(i == 1, i == 2, b);
            chk("fuse busy", 16'h1, {15'h0, b});
        end
        chk("fuse ports", {fv[0], fv[1]}, {f_lo, f_hi});
        chk("fuse ext", {8'h00, fv[2]}, {8'h00, f_ext});
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_FUSE);
        for (int i = 0; i < 3; i++) begin
            u_prog.read(i == 1, i != 0, v);
            chk("fuse read", {8'h00, fv[i]}, {8'h00, v});
        end
        $display("fuse done");
    endtask
    task automatic t_lock();
        logic [7:0] wv [4] = '{8'hef, 8'hff, 8'hfc, 8'hc3};
        logic [7:0] ev [4] = '{8'hef, 8'hef, 8'hec, 8'hec};
        logic b;
        logic [7:0] v;
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_LOCK);
        for (int i = 0; i < 4; i++) begin
            u_prog.load(`PPP_ACT_DATA, 1'b0, wv[i]);
            u_prog.write(1'b0, 1'b0, b);
            chk("lock bits", {8'h00, ev[i]}, {8'h00, lock});
        end
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_FUSE);
        u_prog.read(1'b1, 1'b0, v);
        chk("lock read", 16'h00ec, {8'h00, v});
        $display("lock done");
    endtask
    task automatic t_sig();
        logic [7:0] v;
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_SIG);
        for (int i = 0; i < 3; i++) begin
            u_prog.load(`PPP_ACT_ADDR, 1'b0, 8'(i));
            u_prog.read(1'b0, 1'b0, v);
            chk("signature", {8'h00, SIG[i]}, {8'h00, v});
        end
        u_prog.load(`PPP_ACT_ADDR, 1'b0, 8'h00);
        u_prog.read(1'b1, 1'b0, v);
        chk("calibration", {8'h00, CAL}, {8'h00, v});
        chk("bus released", 16'h0, {15'h0, oe});
        $display("signature done");
    endtask
    // watchdog far past test length
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        complete_run();
    end
    initial begin
        rst = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        u_prog.step(3);
        chk("reset ready oe", 16'h2, {14'h0, rdy, oe});
        chk("reset fuses", 16'hffff, {f_lo, f_hi});
        chk("reset lock ext", 16'hffff, {lock, f_ext});
        $display("reset done");
        t_flash();
        t_eeprom();
        t_fuse();
        t_lock();
        t_sig();
        complete_run();
    end
endmodule // testbench
